/* slic_bench.sv */
`timescale 1ns/10ps
module slic_bench;
  logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, extS, isoS, extClockSelect, strapError, pipeRxOe;
  logic extClockSelectStrapIn, extClockSelectStrapOut, extClockSelectStrapOe;
  logic parallelWidthStrapIn, parallelWidthStrapOut, parallelWidthStrapOe;
  logic coreRxElecIdle, corePhyStatus, coreUlpiDrive, corePclk, pclkOut, pclkOe;
  logic [1:0] bresp, rresp, refS, refFreqCode;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr, ulpiDataIn, ulpiDataOut, ulpiDataOe, coreUlpiData;
  logic [7:0] coreUlpiRx, refFreqMhz;
  logic [31:0] wdata, rdata;
  slic_pkg::slic_tx_type pipeTxIn, coreTx;
  slic_pkg::slic_rx_type coreRx, pipeRxOut;
  logic [33:0] respQ[$];
  int err_count, checks;
  logic [7:0] mhz [4] = '{8'h14, 8'h19, 8'h1e, 8'h28};

  slic_top i_slic_top (.*);
  slic_board i_slic_board (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task test_done;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Responses are judged where they are taken, one bus at a time, so one queue serves both.
  always @(negedge clk_sys) begin
    if (bvalid && bready) chk("bresp", respQ.pop_front(), 34'(bresp));
    if (rvalid && rready) chk("rdata", respQ.pop_front(), {rresp, rdata});
  end

  // Handshakes are judged at the falling edge, so the rising edge after them takes them.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    logic ta, tw, tr;
    respQ.push_back(e);
    @(posedge clk_sys);
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= w;
    rready <= !w;
    do begin
      @(negedge clk_sys);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tr = (bvalid && bready) || (rvalid && rready);
      @(posedge clk_sys);
      if (ta) {awvalid, arvalid} <= 2'h0;
      if (tw) wvalid <= 1'b0;
    end while (!tr);
    {bready, rready} <= 2'h0;
  endtask : bus

  task tx(input logic iso);
    slic_pkg::slic_tx_type v;
    v = slic_pkg::slic_tx_type'(18'($urandom));
    @(posedge clk_sys);
    pipeTxIn <= v;
    coreRx <= slic_pkg::slic_rx_type'(19'($urandom));
    {coreRxElecIdle, corePhyStatus, coreUlpiData, coreUlpiDrive, corePclk} <= 12'($urandom);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("tx", 34'(iso ? 18'h0 : 18'(v)), 34'(coreTx));
    chk("oe", 34'({2{!iso}}), 34'({pclkOe, pipeRxOe}));
  endtask : tx

  // Each pass resets with new straps, then exercises isolation and its release.
  initial begin
    // Reset is lowered by a non-blocking write so the design's reset edge is never missed.
    rst_b <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, extS, isoS} = '0;
    {awaddr, araddr, wdata, wstrb, refS, pipeTxIn, coreRx, coreUlpiData} = '0;
    {coreRxElecIdle, corePhyStatus, coreUlpiDrive, corePclk} = '0;
    void'($urandom(32'h558a59f6));
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      {extS, refS, isoS} <= {k[1], k[1:0], !k[0]};
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      {extS, refS, isoS} <= ~{extS, refS, isoS};
      @(negedge clk_sys);
      chk("clksel", 34'(k[1]), 34'(extClockSelect));
      chk("mhz", 34'(mhz[k[1:0]]), 34'(refFreqMhz));
      chk("strap_err", 34'h0, 34'(strapError));
      bus(0, slic_pkg::STATUS_ADDR, 0, 34'({!k[0], !k[0], 2'h0, k[1:0], k[1]}) | 34'h100);
      bus(0, slic_pkg::FREQ_ADDR, 0, 34'(mhz[k[1:0]]));
      bus(0, slic_pkg::CTRL_ADDR, 0, 34'(!k[0]));
      tx(!k[0]);
      bus(1, slic_pkg::CTRL_ADDR, 32'h0, 34'(slic_pkg::RESP_OKAY));
      tx(1'b0);
      bus(1, slic_pkg::CTRL_ADDR, 32'h1, 34'(slic_pkg::RESP_OKAY));
      tx(1'b1);
      bus(1, 8'h40, $urandom, 34'(slic_pkg::RESP_SLVERR));
      bus(0, 8'h40, 0, {slic_pkg::RESP_SLVERR, 32'h0});
      $display("test %0d done", k);
    end
    test_done();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule : slic_bench

bind slic_top slic_checker i_slic_checker (.*);

/* slic_board.sv */
`timescale 1ns/10ps
// Strap resistors: a pin shows the design's level while driven, else its strap.
module slic_board (
  input  wire logic       extS,
  input  wire logic [1:0] refS,
  input  wire logic       isoS,
  input  wire logic       extClockSelectStrapOut,
  input  wire logic       extClockSelectStrapOe,
  input  wire logic       parallelWidthStrapOut,
  input  wire logic       parallelWidthStrapOe,
  input  wire logic [7:0] ulpiDataOut,
  input  wire logic [7:0] ulpiDataOe,
  output logic            extClockSelectStrapIn,
  output logic            parallelWidthStrapIn,
  output logic [7:0]      ulpiDataIn
);
  logic [7:0] strap;
  // Width straps are tied low; the low data bits fall to their pull-downs.
  assign strap = {isoS, 1'b0, refS, 4'h0};
  assign ulpiDataIn = (ulpiDataOe & ulpiDataOut) | (~ulpiDataOe & strap);
  assign extClockSelectStrapIn = extClockSelectStrapOe ? extClockSelectStrapOut : extS;
  assign parallelWidthStrapIn = parallelWidthStrapOe & parallelWidthStrapOut;
endmodule : slic_board

/* slic_checker.sv */
`timescale 1ns/10ps
// Watches the applied strap settings and the gating of the parallel path.
module slic_checker (
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic                  extClockSelectStrapIn,
  input wire logic [7:0]            ulpiDataIn,
  input wire slic_pkg::slic_tx_type pipeTxIn,
  input wire slic_pkg::slic_tx_type coreTx,
  input wire slic_pkg::slic_rx_type coreRx,
  input wire slic_pkg::slic_rx_type pipeRxOut,
  input wire logic                  pipeRxOe,
  input wire logic                  corePclk,
  input wire logic                  pclkOut,
  input wire logic                  pclkOe,
  input wire logic                  extClockSelect,
  input wire logic [1:0]            refFreqCode,
  input wire logic [7:0]            refFreqMhz,
  input wire logic [7:0]            ulpiDataOut,
  input wire logic [7:0]            ulpiDataOe,
  input wire logic [7:0]            coreUlpiData,
  input wire logic                  coreUlpiDrive,
  input wire logic [7:0]            coreUlpiRx,
  input wire logic                  coreRxElecIdle,
  input wire logic                  corePhyStatus,
  input wire logic                  extClockSelectStrapOut,
  input wire logic                  extClockSelectStrapOe,
  input wire logic                  parallelWidthStrapOut,
  input wire logic                  parallelWidthStrapOe
);
  localparam logic [7:0] MHZ [4] = '{slic_pkg::FREQ_20_MHZ, slic_pkg::FREQ_25_MHZ,
    slic_pkg::FREQ_30_MHZ, slic_pkg::FREQ_40_MHZ};
  logic [1:0] cnt;
  logic       capExt;
  logic       capIso;
  logic [1:0] capRef;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Counts edges after release and keeps the pin levels seen at the capture edge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
      capExt <= 1'b0;
      capIso <= 1'b0;
      capRef <= 2'h0;
    end else begin
      if (cnt != 2'h3) begin
        cnt <= cnt + 2'h1;
      end
      if (cnt == 2'h0) begin
        capExt <= extClockSelectStrapIn;
        capIso <= ulpiDataIn[slic_pkg::ULPI_ISO_BIT];
        capRef <= ulpiDataIn[slic_pkg::ULPI_REF_HI_BIT -: 2];
      end
    end
  end

  a_freq_map: assert property (refFreqMhz == MHZ[refFreqCode])
    else $error("reference MHz does not match the code");
  a_strap_hold: assert property (cnt == 2'h3 |->
    extClockSelect == capExt && refFreqCode == capRef) else $error("settings drifted");
  a_iso_entry: assert property (cnt == 2'h2 |-> pipeRxOe == !capIso)
    else $error("isolate state differs from the captured strap");
  a_tx_block: assert property (!pipeRxOe && !$past(pipeRxOe) |-> coreTx == '0)
    else $error("transmit word passed while isolated");
  a_tx_pass: assert property (pipeRxOe && $past(pipeRxOe) |->
    coreTx == $past(pipeTxIn)) else $error("transmit word lost");
  a_rx_pass: assert property (pipeRxOe && $past(pipeRxOe) |->
    pipeRxOut == $past(coreRx)) else $error("receive word lost");
  a_pclk_gate: assert property (pclkOe == pipeRxOe &&
    (!pclkOe || pclkOut == corePclk)) else $error("clock output gating wrong");
  // The first edge after release still shows reset state, so both checks wait one edge.
  a_ulpi_live: assert property ($past(rst_b) |->
    coreUlpiRx == $past(ulpiDataIn) && ulpiDataOut == $past(coreUlpiData) &&
    ulpiDataOe == {8{$past(cnt) != 2'h0 && $past(coreUlpiDrive)}})
    else $error("ULPI pins not following the core");
  a_pin_resume: assert property ($past(rst_b) |->
    extClockSelectStrapOut == $past(coreRxElecIdle) &&
    parallelWidthStrapOut == $past(corePhyStatus) &&
    extClockSelectStrapOe == ($past(cnt) != 2'h0) &&
    parallelWidthStrapOe == ($past(cnt) != 2'h0))
    else $error("shared strap pins not back to their signal use");
  a_reset_clear: assert property (disable iff (1'b0) !rst_b |->
    !pipeRxOe && coreTx == '0 && !extClockSelect) else $error("reset left state");
endmodule : slic_checker

/* slic_pkg.sv */
package slic_pkg;

  // Parallel interface widths and register bus width.
  localparam int PIPE_WIDTH = 16;
  localparam int PIPE_K_WIDTH = 2;
  localparam int ULPI_WIDTH = 8;
  localparam int BUS_WIDTH = 32;
  localparam int ADDR_WIDTH = 8;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] FREQ_ADDR = 8'h08;

  // Control register fields and reset value.
  localparam int CTRL_ISOLATE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register field positions.
  localparam int STAT_EXT_CLK_BIT = 0;
  localparam int STAT_REF_CODE_LSB = 1;
  localparam int STAT_PIPE_W_BIT = 3;
  localparam int STAT_ULPI_W_BIT = 4;
  localparam int STAT_ISO_STRAP_BIT = 5;
  localparam int STAT_ISOLATE_BIT = 6;
  localparam int STAT_STRAP_ERR_BIT = 7;
  localparam int STAT_CAPTURED_BIT = 8;

  // Positions of the straps on the shared ULPI data pins.
  localparam int ULPI_ISO_BIT = 7;
  localparam int ULPI_WIDTH_BIT = 6;
  localparam int ULPI_REF_HI_BIT = 5;
  localparam int ULPI_REF_LO_BIT = 4;

  // Reference frequency codes and their frequencies in MHz.
  localparam logic [1:0] REF_CODE_20 = 2'h0;
  localparam logic [1:0] REF_CODE_25 = 2'h1;
  localparam logic [1:0] REF_CODE_30 = 2'h2;
  localparam logic [7:0] FREQ_20_MHZ = 8'h14;
  localparam logic [7:0] FREQ_25_MHZ = 8'h19;
  localparam logic [7:0] FREQ_30_MHZ = 8'h1e;
  localparam logic [7:0] FREQ_40_MHZ = 8'h28;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Strap decisions held after capture.
  typedef struct packed {
    logic       captured;
    logic       extClockSelect;
    logic [1:0] refFreqCode;
    logic       parallelWidth;
    logic       ulpiWidth;
    logic       isolateStrap;
  } slic_strap_type;

  // Parallel transmit word with its control-character flags.
  typedef struct packed {
    logic [PIPE_WIDTH-1:0]   data;
    logic [PIPE_K_WIDTH-1:0] dataK;
  } slic_tx_type;

  // Parallel receive word with its flags.
  typedef struct packed {
    logic [PIPE_WIDTH-1:0]   data;
    logic [PIPE_K_WIDTH-1:0] dataK;
    logic                    valid;
  } slic_rx_type;

  // Whole state of the block.
  typedef struct packed {
    slic_strap_type          strap;
    logic                    isolate;
    logic                    awHeld;
    logic [ADDR_WIDTH-1:0]   awAddr;
    logic                    wHeld;
    logic [BUS_WIDTH-1:0]    wData;
    logic [3:0]              wStrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [BUS_WIDTH-1:0]    rdata;
    logic [1:0]              rresp;
    slic_tx_type             tx;
    slic_rx_type             rx;
    logic                    rxElecIdleOut;
    logic                    rxElecIdleOe;
    logic                    phyStatusOut;
    logic                    phyStatusOe;
    logic [ULPI_WIDTH-1:0]   ulpiOut;
    logic [ULPI_WIDTH-1:0]   ulpiOe;
    logic [ULPI_WIDTH-1:0]   ulpiIn;
  } slic_state_type;

endpackage : slic_pkg

/* slic_top.sv */
`timescale 1ns/10ps
// How it works
// R1 - Capture all straps at reset release, hold.
// R2 - Low reset clears everything asynchronously.
// R3 - Clock strap: 0 crystal, 1 external clock.
// R4 - Board holds parallel width strap low.
// R5 - Board holds ULPI width strap low.
// R6 - Frequency code 00/01/10 means 20/25/30 MHz.
// R7 - Isolate strap high enters isolate mode.
// R8 - Isolated: parallel transmit inputs are ignored.
// R9 - Isolated: clock and receive outputs tri-stated.
// R10 - Isolated: ULPI side keeps working normally.
// R11 - Clearing isolate bit restores parallel interface.
// R12 - Captured pins resume functions; settings stay.
// R13 - Frequency code 11 means 40 MHz.
module slic_top #(
  parameter int PIPE_W = slic_pkg::PIPE_WIDTH,
  parameter int ULPI_W = slic_pkg::ULPI_WIDTH
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  // Register bus.
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [slic_pkg::ADDR_WIDTH-1:0] awaddr,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [slic_pkg::BUS_WIDTH-1:0] wdata,
  input  wire logic [3:0]                    wstrb,
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [slic_pkg::ADDR_WIDTH-1:0] araddr,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [slic_pkg::BUS_WIDTH-1:0]     rdata,
  output logic [1:0]                         rresp,
  // Shared strap pins.
  input  wire logic                          extClockSelectStrapIn,
  output logic                               extClockSelectStrapOut,
  output logic                               extClockSelectStrapOe,
  input  wire logic                          parallelWidthStrapIn,
  output logic                               parallelWidthStrapOut,
  output logic                               parallelWidthStrapOe,
  input  wire logic [ULPI_W-1:0]             ulpiDataIn,
  output logic [ULPI_W-1:0]                  ulpiDataOut,
  output logic [ULPI_W-1:0]                  ulpiDataOe,
  // Pin functions of the shared pins, from and to the core.
  input  wire logic                          coreRxElecIdle,
  input  wire logic                          corePhyStatus,
  input  wire logic [ULPI_W-1:0]             coreUlpiData,
  input  wire logic                          coreUlpiDrive,
  output logic [ULPI_W-1:0]                  coreUlpiRx,
  // Parallel transmit side.
  input  wire slic_pkg::slic_tx_type         pipeTxIn,
  output slic_pkg::slic_tx_type              coreTx,
  // Parallel receive side.
  input  wire slic_pkg::slic_rx_type         coreRx,
  output slic_pkg::slic_rx_type              pipeRxOut,
  output logic                               pipeRxOe,
  input  wire logic                          corePclk,
  output logic                               pclkOut,
  output logic                               pclkOe,
  // Applied settings.
  output logic                               extClockSelect,
  output logic [1:0]                         refFreqCode,
  output logic [7:0]                         refFreqMhz,
  output logic                               strapError
);

  // Only the documented widths are served by the strap positions and structs.
  if (PIPE_W != slic_pkg::PIPE_WIDTH || ULPI_W != slic_pkg::ULPI_WIDTH) begin : gWidthCheck
    $error("slic_top: unsupported parallel or ULPI width");
  end

  slic_pkg::slic_state_type state;
  slic_pkg::slic_state_type next_state;
  logic [7:0]               freqMhz;
  logic [31:0]              statusWord;

  // Frequency lookup from the latched code.
  always_comb begin
    case (state.strap.refFreqCode)
      slic_pkg::REF_CODE_20: freqMhz = slic_pkg::FREQ_20_MHZ; // [R6]
      slic_pkg::REF_CODE_25: freqMhz = slic_pkg::FREQ_25_MHZ; // [R6]
      slic_pkg::REF_CODE_30: freqMhz = slic_pkg::FREQ_30_MHZ; // [R6]
      default:               freqMhz = slic_pkg::FREQ_40_MHZ; // [R13]
    endcase
  end

  // Status word shows the latched straps and the live isolate state.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[slic_pkg::STAT_EXT_CLK_BIT] = state.strap.extClockSelect;
    statusWord[slic_pkg::STAT_REF_CODE_LSB +: 2] = state.strap.refFreqCode;
    statusWord[slic_pkg::STAT_PIPE_W_BIT] = state.strap.parallelWidth;
    statusWord[slic_pkg::STAT_ULPI_W_BIT] = state.strap.ulpiWidth;
    statusWord[slic_pkg::STAT_ISO_STRAP_BIT] = state.strap.isolateStrap;
    statusWord[slic_pkg::STAT_ISOLATE_BIT] = state.isolate;
    statusWord[slic_pkg::STAT_STRAP_ERR_BIT] = strapError;
    statusWord[slic_pkg::STAT_CAPTURED_BIT] = state.strap.captured;
  end

  // Next-state logic for straps, isolate control, pins and the bus slave.
  always_comb begin
    next_state = state;

    // The pins are sampled on the first edge after release; from then on the
    // captured flag blocks any further pin activity from reaching the settings.
    if (!state.strap.captured) begin
      next_state.strap.captured       = 1'b1; // [R1]
      next_state.strap.extClockSelect = extClockSelectStrapIn; // [R1] [R3]
      next_state.strap.parallelWidth  = parallelWidthStrapIn; // [R1]
      next_state.strap.ulpiWidth      = ulpiDataIn[slic_pkg::ULPI_WIDTH_BIT]; // [R1]
      next_state.strap.refFreqCode    = {ulpiDataIn[slic_pkg::ULPI_REF_HI_BIT],
                                         ulpiDataIn[slic_pkg::ULPI_REF_LO_BIT]}; // [R1] [R6]
      next_state.strap.isolateStrap   = ulpiDataIn[slic_pkg::ULPI_ISO_BIT]; // [R1]
      next_state.isolate              = ulpiDataIn[slic_pkg::ULPI_ISO_BIT]; // [R7]
    end

    // Shared pins stay undriven until capture so the strap resistors win.
    next_state.rxElecIdleOut = coreRxElecIdle; // [R12]
    next_state.phyStatusOut  = corePhyStatus; // [R12]
    next_state.ulpiOut       = coreUlpiData; // [R12]
    next_state.ulpiIn        = ulpiDataIn; // [R10]
    next_state.rxElecIdleOe  = state.strap.captured; // [R12]
    next_state.phyStatusOe   = state.strap.captured; // [R12]
    next_state.ulpiOe        = {ULPI_W{state.strap.captured & coreUlpiDrive}}; // [R10] [R12]

    // Transmit words are forced to zero while isolated so junk never reaches the core.
    if (state.isolate || !state.strap.captured) begin
      next_state.tx = '0; // [R8]
    end else begin
      next_state.tx = pipeTxIn; // [R11]
    end
    next_state.rx = coreRx;

    // Write channel: address and data are taken independently, in either order.
    if (awvalid && awready) begin
      next_state.awHeld = 1'b1;
      next_state.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_state.wHeld = 1'b1;
      next_state.wData = wdata;
      next_state.wStrb = wstrb;
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.awHeld && state.wHeld && !state.bvalid) begin
      next_state.awHeld = 1'b0;
      next_state.wHeld  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = slic_pkg::RESP_OKAY;
      if (state.awAddr == slic_pkg::CTRL_ADDR) begin
        if (state.wStrb[0]) begin
          next_state.isolate = state.wData[slic_pkg::CTRL_ISOLATE_BIT]; // [R11]
        end
      end else if (state.awAddr == slic_pkg::STATUS_ADDR ||
                   state.awAddr == slic_pkg::FREQ_ADDR) begin
        next_state.bresp = slic_pkg::RESP_OKAY;
      end else begin
        next_state.bresp = slic_pkg::RESP_SLVERR;
      end
    end

    // Read channel: one read in flight, answered the cycle after it is taken.
    if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = slic_pkg::RESP_OKAY;
      if (araddr == slic_pkg::CTRL_ADDR) begin
        next_state.rdata = 32'h0000_0000;
        next_state.rdata[slic_pkg::CTRL_ISOLATE_BIT] = state.isolate;
      end else if (araddr == slic_pkg::STATUS_ADDR) begin
        next_state.rdata = statusWord;
      end else if (araddr == slic_pkg::FREQ_ADDR) begin
        next_state.rdata = {24'h00_0000, freqMhz};
      end else begin
        next_state.rdata = 32'h0000_0000;
        next_state.rresp = slic_pkg::RESP_SLVERR;
      end
    end
  end

  // State register; reset loads constants only, the straps arrive one edge later.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0; // [R2]
    end else begin
      state <= next_state;
    end
  end

  // Bus handshakes; a new write is held off until its response has been taken.
  assign awready = !state.awHeld && !state.bvalid;
  assign wready  = !state.wHeld && !state.bvalid;
  assign arready = !state.rvalid;
  assign bvalid  = state.bvalid;
  assign bresp   = state.bresp;
  assign rvalid  = state.rvalid;
  assign rdata   = state.rdata;
  assign rresp   = state.rresp;

  // Shared pin drivers.
  assign extClockSelectStrapOut = state.rxElecIdleOut;
  assign extClockSelectStrapOe  = state.rxElecIdleOe;
  assign parallelWidthStrapOut  = state.phyStatusOut;
  assign parallelWidthStrapOe   = state.phyStatusOe;
  assign ulpiDataOut            = state.ulpiOut;
  assign ulpiDataOe             = state.ulpiOe;
  assign coreUlpiRx             = state.ulpiIn;

  // Parallel side; the clock is gated only in its enable, never in its edge.
  assign coreTx    = state.tx;
  assign pipeRxOut = state.rx;
  assign pipeRxOe  = state.strap.captured && !state.isolate; // [R9] [R11]
  assign pclkOut   = corePclk;
  assign pclkOe    = state.strap.captured && !state.isolate; // [R9] [R11]

  // Applied settings; a set width strap cannot be served and is flagged.
  assign extClockSelect = state.strap.extClockSelect; // [R3]
  assign refFreqCode    = state.strap.refFreqCode;
  assign refFreqMhz     = freqMhz;
  assign strapError     = state.strap.parallelWidth | state.strap.ulpiWidth; // [R4] [R5]

endmodule : slic_top
